//--- hw/tcc_core.v
// Purpose : Counter core of an 8-bit timer with two compare units
// Assumes : MCLK 40 MHz, RST_N synchronous active low, plain reg port
// Notes   : External count pin is synchronised before edge detection
//
// Behaviour
// RULE1 - Count and compare values are CPU registers
// RULE2 - Two independent compare units A and B
// RULE3 - Compare values double buffered
// RULE4 - Compare runs every cycle
// RULE5 - Match sets that unit's flag
// RULE6 - Match drives waveform outputs
// RULE7 - All three flags in one register
// RULE8 - Each source gated by mask bit
// RULE9 - Tick from prescaler or external pin
// RULE10 - Select picks source and edge
// RULE11 - Three-bit select field in control B
// RULE12 - Select zero stops the counter
// RULE13 - Tick clears, increments or decrements
// RULE14 - CPU accesses count anytime
// RULE15 - CPU count write beats tick
// RULE16 - Mode from control A and B bits
// RULE17 - Bottom signalled at 0x00
// RULE18 - Max signalled at 0xFF
// RULE19 - Top is 0xFF or compare A
// RULE20 - Overflow point depends on mode
// RULE21 - Flag sets on tick after match
// RULE22 - Write one or ack clears flag
// RULE23 - Normal mode wraps, overflow at zero
// RULE24 - CTC clears on compare A match
// RULE25 - Everything resets to zero, stopped
//
// Decided for this implementation: the address map and strobed register access.
`include "tcc_map.vh"

module tcc_core (
    input  wire       MCLK,
    input  wire       RST_N,
    input  wire [3:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    input  wire       EXT_COUNT_PIN,
    output reg  [7:0] RDATA,
    output reg        IRQ_OVF,
    output reg        IRQ_CMP_A,
    output reg        IRQ_CMP_B,
    output reg        COMPARE_A_OUTPUT,
    output reg        COMPARE_B_OUTPUT,
    output reg        AT_BOTTOM,
    output reg        AT_MAX
);

// ----------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------
function is_pwm;
    input [2:0] m;
    begin
        is_pwm = (m == `TCC_WGM_PC_FF) || (m == `TCC_WGM_FAST_FF) ||
                 (m == `TCC_WGM_PC_OCA) || (m == `TCC_WGM_FAST_OCA);
    end
endfunction

function is_phase;
    input [2:0] m;
    begin
        is_phase = (m == `TCC_WGM_PC_FF) || (m == `TCC_WGM_PC_OCA);
    end
endfunction

// New output level for a compare output action
function out_act;
    input [1:0] com;
    input       cur;
    input       up;
    input       pwm;
    begin
        case (com)
            2'h1:    out_act = pwm ? cur : ~cur;
            2'h2:    out_act = pwm ? ~up : 1'b0;
            2'h3:    out_act = pwm ? up : 1'b1;
            default: out_act = cur;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// State
// ----------------------------------------------------------------------
reg  [7:0] timer_control_a;
reg  [7:0] timer_control_b;
reg  [7:0] count_value;
reg  [7:0] compare_a_value;
reg  [7:0] compare_b_value;
reg  [7:0] compare_a_buf;
reg  [7:0] compare_b_buf;
reg  [2:0] timer_mask_register;
reg  [2:0] timer_flag_register;
reg        count_down;
reg        block_match;
reg        match_a_held;
reg        match_b_held;
reg  [`TCC_PRESCALE_W-1:0] prescale;
reg        ext_meta;
reg        ext_sync;
reg        ext_prev;

wire [2:0] clock_source_select = timer_control_b[2:0];
wire       waveform_mode_high  = timer_control_b[`TCC_WGM_HIGH_BIT];
wire       waveform_mode_mid   = timer_control_a[`TCC_WGM_MID_BIT];
wire       waveform_mode_low   = timer_control_a[`TCC_WGM_LOW_BIT];
wire [2:0] mode = {waveform_mode_high, waveform_mode_mid,
                   waveform_mode_low}; // RULE16
wire       pwm   = is_pwm(mode);
wire       phase = is_phase(mode);
wire       top_is_a = (mode == `TCC_WGM_CTC) || mode[2]; // RULE19
wire [7:0] top_value = top_is_a ? compare_a_buf : `TCC_MAX; // RULE19
wire       wr_count = WR && (ADDR == `TCC_OFF_COUNT);

// ----------------------------------------------------------------------
// Clock select and tick
// ----------------------------------------------------------------------
reg        timer_tick;
always @* begin
    case (clock_source_select) // RULE9 RULE10 RULE11
        `TCC_CS_STOP:     timer_tick = 1'b0; // RULE12
        `TCC_CS_DIV1:     timer_tick = 1'b1;
        `TCC_CS_DIV8:     timer_tick = (prescale[2:0] == 3'h7);
        `TCC_CS_DIV64:    timer_tick = (prescale[5:0] == 6'h3F);
        `TCC_CS_DIV256:   timer_tick = (prescale[7:0] == 8'hFF);
        `TCC_CS_DIV1024:  timer_tick = (prescale == 10'h3FF);
        `TCC_CS_EXT_FALL: timer_tick = ext_prev & ~ext_sync;
        `TCC_CS_EXT_RISE: timer_tick = ~ext_prev & ext_sync;
        default:          timer_tick = 1'b0;
    endcase
end

always @(posedge MCLK) begin
    if (!RST_N) begin
        prescale <= {`TCC_PRESCALE_W{1'b0}};
        ext_meta <= 1'b0;
        ext_sync <= 1'b0;
        ext_prev <= 1'b0;
    end else begin
        prescale <= prescale + 1'b1;
        ext_meta <= EXT_COUNT_PIN;
        ext_sync <= ext_meta;
        ext_prev <= ext_sync;
    end
end

// ----------------------------------------------------------------------
// Counter next value
// ----------------------------------------------------------------------
reg  [7:0] next_count;
reg        next_down;
always @* begin
    next_count = count_value;
    next_down  = count_down;
    if (wr_count) begin
        next_count = WDATA; // RULE14 RULE15
    end else if (timer_tick) begin // RULE13
        if (phase) begin
            if (count_down) begin
                next_count = count_value - 8'h01;
                if (count_value == 8'h01)
                    next_down = 1'b0;
            end else begin
                next_count = count_value + 8'h01;
                if (count_value + 8'h01 == top_value)
                    next_down = 1'b1;
            end
        end else if (count_value == top_value && mode != `TCC_WGM_NORMAL) begin
            next_count = `TCC_BOTTOM; // RULE24
        end else begin
            next_count = count_value + 8'h01; // RULE23
        end
    end
end

// Compare runs every cycle, not only on a count change
wire match_a = (count_value == compare_a_buf) && !block_match; // RULE4
wire match_b = (count_value == compare_b_buf) && !block_match; // RULE2

// Overflow at bottom for up modes, at bottom turn for phase modes
wire ovf_evt = timer_tick && !wr_count &&
               (phase ? (count_down && count_value == 8'h01)
                      : (next_count == `TCC_BOTTOM)); // RULE20 RULE23
wire upd_buf = pwm ? (phase ? (timer_tick && count_value == top_value)
                            : ovf_evt) : 1'b1; // RULE3

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
wire       ack = WR && (ADDR == `TCC_OFF_ACK);
wire [2:0] clr = (WR && ADDR == `TCC_OFF_FLAG) ? WDATA[2:0] : 3'h0;
wire [2:0] ack_clr = ack ? WDATA[2:0] : 3'h0;
wire [2:0] set_evt = {timer_tick && match_b_held,
                      timer_tick && match_a_held, ovf_evt};
wire       foc_a = WR && ADDR == `TCC_OFF_CTRL_B && !pwm &&
                   WDATA[`TCC_FOC_A_BIT];
wire       foc_b = WR && ADDR == `TCC_OFF_CTRL_B && !pwm &&
                   WDATA[`TCC_FOC_B_BIT];

always @(posedge MCLK) begin
    if (!RST_N) begin // RULE25
        timer_control_a     <= `TCC_RESET_BYTE;
        timer_control_b     <= `TCC_RESET_BYTE;
        count_value         <= `TCC_RESET_BYTE;
        compare_a_value     <= `TCC_RESET_BYTE;
        compare_b_value     <= `TCC_RESET_BYTE;
        compare_a_buf       <= `TCC_RESET_BYTE;
        compare_b_buf       <= `TCC_RESET_BYTE;
        timer_mask_register <= 3'h0;
        timer_flag_register <= 3'h0;
        count_down          <= 1'b0;
        block_match         <= 1'b0;
        match_a_held        <= 1'b0;
        match_b_held        <= 1'b0;
        COMPARE_A_OUTPUT    <= 1'b0;
        COMPARE_B_OUTPUT    <= 1'b0;
        RDATA               <= 8'h00;
        IRQ_OVF             <= 1'b0;
        IRQ_CMP_A           <= 1'b0;
        IRQ_CMP_B           <= 1'b0;
        AT_BOTTOM           <= 1'b0;
        AT_MAX              <= 1'b0;
    end else begin
        if (WR) begin
            case (ADDR) // RULE1
                `TCC_OFF_CTRL_A: timer_control_a <= WDATA;
                `TCC_OFF_CTRL_B: timer_control_b <= {4'h0, WDATA[3:0]};
                `TCC_OFF_CMP_A:  compare_a_value <= WDATA;
                `TCC_OFF_CMP_B:  compare_b_value <= WDATA;
                `TCC_OFF_MASK:   timer_mask_register <= WDATA[2:0]; // RULE8
                default: ;
            endcase
        end
        count_value <= next_count;
        count_down  <= next_down;
        // Count write blocks matches until the next tick
        if (wr_count)
            block_match <= 1'b1;
        else if (timer_tick)
            block_match <= 1'b0;
        // Match is held and turned into a flag on the following tick
        // A count write drops any match held from before the write
        if (wr_count) begin
            match_a_held <= 1'b0;
            match_b_held <= 1'b0;
        end else if (timer_tick) begin
            match_a_held <= match_a; // RULE21
            match_b_held <= match_b; // RULE21
        end else begin
            match_a_held <= match_a_held | match_a;
            match_b_held <= match_b_held | match_b;
        end
        if (upd_buf) begin
            compare_a_buf <= compare_a_value; // RULE3
            compare_b_buf <= compare_b_value; // RULE3
        end
        // Set beats clear in the same cycle
        timer_flag_register <= (timer_flag_register & ~(clr | ack_clr))
                               | set_evt; // RULE5 RULE7 RULE22
        if ((timer_tick && match_a_held) || foc_a)
            COMPARE_A_OUTPUT <= out_act(timer_control_a[7:6],
                                        COMPARE_A_OUTPUT,
                                        !count_down, pwm); // RULE6
        if ((timer_tick && match_b_held) || foc_b)
            COMPARE_B_OUTPUT <= out_act(timer_control_a[5:4],
                                        COMPARE_B_OUTPUT,
                                        !count_down, pwm); // RULE6
        IRQ_OVF   <= timer_flag_register[`TCC_OVF_BIT] &
                     timer_mask_register[`TCC_OVF_BIT]; // RULE8
        IRQ_CMP_A <= timer_flag_register[`TCC_CMPA_BIT] &
                     timer_mask_register[`TCC_CMPA_BIT]; // RULE8
        IRQ_CMP_B <= timer_flag_register[`TCC_CMPB_BIT] &
                     timer_mask_register[`TCC_CMPB_BIT]; // RULE8
        AT_BOTTOM <= (next_count == `TCC_BOTTOM); // RULE17
        AT_MAX    <= (next_count == `TCC_MAX); // RULE18
        if (RD) begin
            case (ADDR)
                `TCC_OFF_CTRL_A: RDATA <= timer_control_a;
                `TCC_OFF_CTRL_B: RDATA <= timer_control_b;
                `TCC_OFF_COUNT:  RDATA <= count_value; // RULE14
                `TCC_OFF_CMP_A:  RDATA <= compare_a_value;
                `TCC_OFF_CMP_B:  RDATA <= compare_b_value;
                `TCC_OFF_MASK:   RDATA <= {5'h00, timer_mask_register};
                `TCC_OFF_FLAG:   RDATA <= {5'h00, timer_flag_register};
                default:         RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
end

endmodule // tcc_core

//--- inc/tcc_map.vh
// Purpose : Register offsets, fields and codes of the 8-bit timer core
// Assumes : Plain register port, 8-bit data
// Notes   : Included by the timer core, its assertion checker and its bench
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCC_ADDR_W        4
`define TCC_OFF_CTRL_A    4'h0
`define TCC_OFF_CTRL_B    4'h1
`define TCC_OFF_COUNT     4'h2
`define TCC_OFF_CMP_A     4'h3
`define TCC_OFF_CMP_B     4'h4
`define TCC_OFF_MASK      4'h5
`define TCC_OFF_FLAG      4'h6
`define TCC_OFF_ACK       4'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TCC_WGM_LOW_BIT   0
`define TCC_WGM_MID_BIT   1
`define TCC_COM_A_LSB     6
`define TCC_COM_B_LSB     4
`define TCC_CS_LSB        0
`define TCC_WGM_HIGH_BIT  3
`define TCC_FOC_A_BIT     7
`define TCC_FOC_B_BIT     6
`define TCC_OVF_BIT       0
`define TCC_CMPA_BIT      1
`define TCC_CMPB_BIT      2

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define TCC_RESET_BYTE    8'h00
`define TCC_BOTTOM        8'h00
`define TCC_MAX           8'hFF
`define TCC_CS_STOP       3'h0
`define TCC_CS_DIV1       3'h1
`define TCC_CS_DIV8       3'h2
`define TCC_CS_DIV64      3'h3
`define TCC_CS_DIV256     3'h4
`define TCC_CS_DIV1024    3'h5
`define TCC_CS_EXT_FALL   3'h6
`define TCC_CS_EXT_RISE   3'h7
`define TCC_WGM_NORMAL    3'h0
`define TCC_WGM_PC_FF     3'h1
`define TCC_WGM_CTC       3'h2
`define TCC_WGM_FAST_FF   3'h3
`define TCC_WGM_PC_OCA    3'h5
`define TCC_WGM_FAST_OCA  3'h7
`define TCC_PRESCALE_W    10

`endif

//--- verif/tcc_core_chk.sv
// Purpose : Port assertions for the timer core
// Assumes : One clock, plain register port
// Notes   : Shadows control and mask writes to know the mode
`include "tcc_map.vh"
module tcc_core_chk (
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       IRQ_OVF,
    input wire logic       IRQ_CMP_A,
    input wire logic       IRQ_CMP_B
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cs;
    logic [2:0] wgm;
    logic [2:0] msk;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // ------------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            cs  <= 3'h0;
            wgm <= 3'h0;
            msk <= 3'h0;
        end else if (WR && ADDR == `TCC_OFF_CTRL_B) begin
            cs     <= WDATA[2:0];
            wgm[2] <= WDATA[3];
        end else if (WR && ADDR == `TCC_OFF_CTRL_A) begin
            wgm[1:0] <= WDATA[1:0];
        end else if (WR && ADDR == `TCC_OFF_MASK) begin
            msk <= WDATA[2:0];
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rd_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    a_cnt_wr_back: assert property (WR && ADDR == `TCC_OFF_COUNT ##2
        RD && ADDR == `TCC_OFF_COUNT && cs == 3'h0
        |=> RDATA == $past(WDATA, 3)) else $error("count write lost");
    a_cmp_read_back: assert property (WR && ADDR == `TCC_OFF_CMP_A ##2
        RD && ADDR == `TCC_OFF_CMP_A |=> RDATA == $past(WDATA, 3))
        else $error("compare A readback wrong");
    a_irq_ovf_mask: assert property (IRQ_OVF |-> $past(msk[0]))
        else $error("overflow request while masked");
    a_irq_cmpa_mask: assert property (IRQ_CMP_A |-> $past(msk[1]))
        else $error("compare A request while masked");
    a_irq_cmpb_mask: assert property (IRQ_CMP_B |-> $past(msk[2]))
        else $error("compare B request while masked");
    a_flag_bits_only: assert property ($past(RD && ADDR == `TCC_OFF_FLAG)
        |-> RDATA[7:3] == 5'h00) else $error("flag upper bits set");
    a_unmapped_zero: assert property ($past(RD && ADDR[3])
        |-> RDATA == 8'h00) else $error("unmapped read not zero");
    a_stop_holds: assert property (RD && ADDR == `TCC_OFF_COUNT && cs == 0
        ##2 RD && ADDR == `TCC_OFF_COUNT && cs == 0 && !$past(WR)
        |=> RDATA == $past(RDATA, 2)) else $error("stopped count moved");
    a_div1_step: assert property (RD && ADDR == `TCC_OFF_COUNT && cs == 1
        && wgm == 0 ##2 RD && ADDR == `TCC_OFF_COUNT && cs == 1
        && !$past(WR) |=> RDATA == $past(RDATA, 2) + 8'h02)
        else $error("count did not step by one per tick");
endmodule // tcc_core_chk

bind tcc_core tcc_core_chk tcc_core_chk_inst (.MCLK(MCLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IRQ_OVF(IRQ_OVF), .IRQ_CMP_A(IRQ_CMP_A), .IRQ_CMP_B(IRQ_CMP_B));

//--- verif/tcc_core_tb_top.sv
// Purpose : Self-checking bench of the timer core
// Assumes : 40 MHz clock, reset low for 10 cycles
// Notes   : Prescaled counts checked with one tick of slack
`include "tcc_map.vh"
module tcc_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ext_pin = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d, e;
    logic       wr, rd, irq_ovf, irq_a, irq_b;
    logic       out_a, out_b, at_bot, at_max;
    int         n_fail = 0;
    int         num_checks = 0;
    initial forever #12.5 mclk = ~mclk;
    tcc_cpu_model tcc_cpu_model_inst (.mclk(mclk), .rdata(rdata),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    tcc_core tcc_core_inst (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .EXT_COUNT_PIN(ext_pin),
        .RDATA(rdata), .IRQ_OVF(irq_ovf), .IRQ_CMP_A(irq_a),
        .IRQ_CMP_B(irq_b), .COMPARE_A_OUTPUT(out_a),
        .COMPARE_B_OUTPUT(out_b), .AT_BOTTOM(at_bot), .AT_MAX(at_max));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] v);
        tcc_cpu_model_inst.wr_reg(a, v);
    endtask
    task automatic r(input logic [3:0] a);
        tcc_cpu_model_inst.rd_reg(a, d);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            r(i[3:0]);
            chk(d, 8'h00);
        end
        $display("done t_reset");
    endtask
    task automatic t_regs;
        w(`TCC_OFF_CMP_A, 8'h10);
        r(`TCC_OFF_CMP_A);
        chk(d, 8'h10);
        w(`TCC_OFF_CMP_B, 8'h20);
        r(`TCC_OFF_CMP_B);
        chk(d, 8'h20);
        w(`TCC_OFF_COUNT, 8'hFF);
        @(negedge mclk);
        chk({7'h00, at_max}, 8'h01);
        w(`TCC_OFF_COUNT, 8'h00);
        @(negedge mclk);
        chk({7'h00, at_bot}, 8'h01);
        w(`TCC_OFF_COUNT, 8'h5A);
        r(`TCC_OFF_COUNT);
        chk(d, 8'h5A);
        r(`TCC_OFF_COUNT);
        chk(d, 8'h5A);
        $display("done t_regs");
    endtask
    task automatic t_normal;
        w(`TCC_OFF_MASK, 8'h07);
        w(`TCC_OFF_COUNT, 8'hFD);
        w(`TCC_OFF_CTRL_B, 8'h01);
        r(`TCC_OFF_COUNT);
        r(`TCC_OFF_COUNT);
        w(`TCC_OFF_CTRL_B, 8'h00);
        r(`TCC_OFF_FLAG);
        chk(d, 8'h01);
        chk({7'h00, irq_ovf}, 8'h01);
        w(`TCC_OFF_FLAG, 8'h01);
        r(`TCC_OFF_FLAG);
        chk(d, 8'h00);
        chk({7'h00, irq_ovf}, 8'h00);
        $display("done t_normal");
    endtask
    task automatic t_ctc;
        w(`TCC_OFF_CTRL_A, 8'h02);
        w(`TCC_OFF_CMP_A, 8'h05);
        w(`TCC_OFF_CMP_B, 8'h03);
        w(`TCC_OFF_COUNT, 8'h00);
        w(`TCC_OFF_CTRL_B, 8'h01);
        repeat (30) @(posedge mclk);
        w(`TCC_OFF_CTRL_B, 8'h00);
        r(`TCC_OFF_COUNT);
        chk({7'h00, d <= 8'h05}, 8'h01);
        r(`TCC_OFF_FLAG);
        chk(d & 8'h06, 8'h06);
        w(`TCC_OFF_ACK, 8'h07);
        r(`TCC_OFF_FLAG);
        chk(d, 8'h00);
        w(`TCC_OFF_CTRL_A, 8'hF2);
        w(`TCC_OFF_CTRL_B, 8'hC0);
        @(negedge mclk);
        chk({6'h00, out_a, out_b}, 8'h03);
        w(`TCC_OFF_CTRL_A, 8'h00);
        $display("done t_ctc");
    endtask
    task automatic t_clk;
        for (int c = 6; c < 8; c++) begin
            w(`TCC_OFF_COUNT, 8'h00);
            w(`TCC_OFF_CTRL_B, c[7:0]);
            repeat (3) begin
                repeat (4) @(posedge mclk);
                ext_pin <= 1'b1;
                repeat (4) @(posedge mclk);
                ext_pin <= 1'b0;
            end
            repeat (6) @(posedge mclk);
            w(`TCC_OFF_CTRL_B, 8'h00);
            r(`TCC_OFF_COUNT);
            chk(d, 8'h03);
        end
        for (int c = 2; c < 6; c++) begin
            w(`TCC_OFF_COUNT, 8'h00);
            w(`TCC_OFF_CTRL_B, c[7:0]);
            repeat (1023) @(posedge mclk);
            w(`TCC_OFF_CTRL_B, 8'h00);
            r(`TCC_OFF_COUNT);
            e = 8'(1024 >> (3 * c - 3 - (c > 3 ? c - 3 : 0)));
            chk({7'h00, d + 8'h01 >= e && d <= e + 8'h01}, 8'h01);
        end
        $display("done t_clk");
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_normal();
        t_ctc();
        t_clk();
        summarize();
    end
    initial begin
        #(12000 * 25);
        n_fail++;
        summarize();
    end
endmodule // tcc_core_tb_top

//--- verif/tcc_cpu_model.sv
// Purpose : CPU side of the register port
// Assumes : Strobes one cycle, read data in the cycle after
// Notes   : Gap of one idle cycle between accesses
module tcc_cpu_model (
    input wire logic       mclk,
    input wire logic [7:0] rdata,
    output logic     [3:0] addr,
    output logic     [7:0] wdata,
    output logic           wr,
    output logic           rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        wdata <= ~d; // Stale data must not look valid
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule // tcc_cpu_model
